// ### cpx_pkg.sv
// constants, types and decode helpers for the coprocessor primitive exception checker
// assumes primitives arrive already split into a type code and fields by the response reader
`default_nettype none
package cpx_pkg;
	// exception vector numbers
	localparam logic [7:0] VEC_PROTOCOL = 8'h0d;
	localparam logic [7:0] VEC_FLINE    = 8'h0b;
	localparam logic [7:0] VEC_PRIV     = 8'h08;
	// operation word field positions
	localparam int OPW_TYPE_MSB = 8;
	localparam int OPW_TYPE_LSB = 6;
	localparam int OPW_MODE_MSB = 5;
	localparam int OPW_MODE_LSB = 3;
	localparam int OPW_REG_MSB  = 2;
	localparam int OPW_REG_LSB  = 0;
	// operation word type codes: two that are never coprocessor instructions, and the conditional category
	localparam logic [2:0] OPT_RSVD_A   = 3'h6;
	localparam logic [2:0] OPT_RSVD_B   = 3'h7;
	localparam logic [2:0] OPT_COND     = 3'h1;
	// effective address modes
	localparam logic [2:0] EAM_DREG     = 3'h0;
	localparam logic [2:0] EAM_AREG     = 3'h1;
	localparam logic [2:0] EAM_IND      = 3'h2;
	localparam logic [2:0] EAM_POSTINC  = 3'h3;
	localparam logic [2:0] EAM_PREDEC   = 3'h4;
	localparam logic [2:0] EAM_DISP     = 3'h5;
	localparam logic [2:0] EAM_INDEX    = 3'h6;
	localparam logic [2:0] EAM_EXT      = 3'h7;
	localparam logic [2:0] EAR_ABS_W    = 3'h0;
	localparam logic [2:0] EAR_ABS_L    = 3'h1;
	localparam logic [2:0] EAR_IMM      = 3'h4;
	// operand lengths
	localparam logic [7:0] LEN_BYTE     = 8'h01;
	localparam logic [7:0] LEN_WORD     = 8'h02;
	localparam logic [7:0] LEN_LONG     = 8'h04;
	localparam logic [7:0] LEN_ZERO     = 8'h00;

	// decoded primitive types
	typedef enum logic [4:0] {
		PRIM_BUSY        = 5'h00,
		PRIM_NULL        = 5'h01,
		PRIM_SUPER_CHECK = 5'h02,
		PRIM_XFER_OPWORD = 5'h03,
		PRIM_XFER_ISTRM  = 5'h04,
		PRIM_EVAL_EA     = 5'h05,
		PRIM_EVAL_DATA   = 5'h06,
		PRIM_WRITE_PREV  = 5'h07,
		PRIM_TAKE_ADDR   = 5'h08,
		PRIM_XFER_TOS    = 5'h09,
		PRIM_XFER_MREG   = 5'h0a,
		PRIM_XFER_MCTRL  = 5'h0b,
		PRIM_XFER_MMULTI = 5'h0c,
		PRIM_XFER_CMULTI = 5'h0d,
		PRIM_XFER_STATUS = 5'h0e,
		PRIM_TAKE_PRE    = 5'h0f,
		PRIM_TAKE_MID    = 5'h10,
		PRIM_TAKE_POST   = 5'h11
	} cpx_prim_t;

	// stack frame choices
	typedef enum logic [1:0] {
		FRAME_PRE4   = 2'h0,
		FRAME_MID10  = 2'h1,
		FRAME_POST6  = 2'h2
	} cpx_frame_t;

	// exception classes
	typedef enum logic [2:0] {
		KIND_NONE     = 3'h0,
		KIND_PROTOCOL = 3'h1,
		KIND_FLINE    = 3'h2,
		KIND_PRIV     = 3'h3,
		KIND_TAKEN    = 3'h4
	} cpx_kind_t;

	// valid-address categories carried by a data primitive
	typedef enum logic [1:0] {
		EAC_CONTROL_ALT = 2'h0,
		EAC_ALTERABLE   = 2'h1,
		EAC_MEMORY      = 2'h2,
		EAC_ANY         = 2'h3
	} cpx_eacls_t;

	// primitives that must carry come-again set in a conditional instruction
	function automatic logic prim_marked(input logic [4:0] p);
		case (p)
			PRIM_SUPER_CHECK, PRIM_XFER_OPWORD, PRIM_XFER_ISTRM, PRIM_TAKE_ADDR,
			PRIM_XFER_TOS, PRIM_XFER_MREG, PRIM_XFER_MMULTI: prim_marked = 1'b1;
			default: prim_marked = 1'b0;
		endcase
	endfunction

	// control alterable address mode
	function automatic logic ea_ctrl_alt(input logic [5:0] ea);
		case (ea[5:3])
			EAM_IND, EAM_DISP, EAM_INDEX: ea_ctrl_alt = 1'b1;
			EAM_EXT: ea_ctrl_alt = (ea[2:0] == EAR_ABS_W) || (ea[2:0] == EAR_ABS_L);
			default: ea_ctrl_alt = 1'b0;
		endcase
	endfunction

	// alterable address mode (registers and memory, not pc-relative or immediate)
	function automatic logic ea_alterable(input logic [5:0] ea);
		ea_alterable = (ea[5:3] != EAM_EXT) || (ea[2:0] == EAR_ABS_W) || (ea[2:0] == EAR_ABS_L);
	endfunction

	// true when the address mode lies in the category the primitive allows
	function automatic logic ea_in_class(input logic [5:0] ea, input logic [1:0] cls);
		case (cls)
			EAC_CONTROL_ALT: ea_in_class = ea_ctrl_alt(ea);
			EAC_ALTERABLE:   ea_in_class = ea_alterable(ea);
			EAC_MEMORY:      ea_in_class = (ea[5:3] != EAM_DREG) && (ea[5:3] != EAM_AREG);
			default:         ea_in_class = 1'b1;
		endcase
	endfunction
endpackage
`default_nettype wire

// ### cpx_op_if.sv
// link between the checker core and its operation word decoder
// assumes both ends sit in the processor clock domain
`default_nettype none
interface cpx_op_if;
	logic [15:0] op_word;     // latched operation word
	logic        recognised;  // outer decoder found a valid instruction
	logic        reserved;    // type field is a never-coprocessor code
	logic        invalid;     // word may not start a coprocessor instruction
	logic        conditional; // instruction is of the conditional category
	logic [5:0]  ea;          // effective address field

	modport core (output op_word, output recognised, input reserved, input invalid,
		input conditional, input ea);
	modport dec  (input op_word, input recognised, output reserved, output invalid,
		output conditional, output ea);
endinterface
`default_nettype wire

// ### cpx_op_decoder.sv
// operation word classifier for the coprocessor exception checker
// assumes the word is held stable in the interface by the core
`default_nettype none
module cpx_op_decoder
	import cpx_pkg::*;
(
	cpx_op_if.dec op
);
	logic [2:0] op_type; // category bits of the operation word

	// split the word and classify it
	always_comb begin
		op_type        = op.op_word[OPW_TYPE_MSB:OPW_TYPE_LSB];
		op.reserved    = (op_type == OPT_RSVD_A) || (op_type == OPT_RSVD_B);
		op.invalid     = op.reserved || !op.recognised;
		op.conditional = (op_type == OPT_COND);
		op.ea          = op.op_word[OPW_MODE_MSB:OPW_REG_LSB];
	end
endmodule
`default_nettype wire

// ### cpx_checker.sv
// main processor side exception checker for the coprocessor interface
// assumes primitives are already split into type and fields, and that the
// surrounding sequencer performs the control register write and stacking
// Summary of operation
// - undecodable primitive raises protocol violation
// - odd instruction stream length violates; zero legal
// - listed primitives violate inside conditional instructions
// - evaluate-address needs control alterable mode, else line-F
// - register direct data length must be 1,2,4
// - immediate data length odd above one violates
// - nonalterable write or class mismatch gives line-F
// - top-of-stack length must be 1,2,4
// - unknown control register select violates
// - coprocessor multi-register odd length violates; mode checked
// - supervisor check in user state: privilege
// - status transfer: trace pending, odd scan error
// - marked primitive without come-again violates conditionally
// - take-exception primitive uses its own vector
// - protocol violation writes no control register
// - protocol violation: mid frame, vector 13
// - unchanged return after protocol violation re-reads response register
// - reserved type codes: line-F, no bus access
// - unrecognised word: line-F, no control write
// - invalid primitive line-F writes abort mask first
// - bus error on start access: line-F
// - line-F: four-word pre frame, vector 11
`default_nettype none
module cpx_checker
	import cpx_pkg::*;
(
	input  wire logic        i_sys_clk,         // processor clock
	input  wire logic        i_reset_n,         // asynchronous reset, active low
	input  wire logic        i_op_check,        // pulse: new operation word to check
	input  wire logic [15:0] i_op_word,         // operation word
	input  wire logic        i_op_recognised,   // outer decoder recognised the word
	input  wire logic        i_start_done,      // pulse: starting register access ended
	input  wire logic        i_start_bus_error, // that access ended in bus error
	input  wire logic        i_prim_valid,      // pulse: primitive read from response register
	input  wire logic [4:0]  i_prim_type,       // decoded primitive type
	input  wire logic        i_come_again_bit,  // come-again bit of the primitive
	input  wire logic [7:0]  i_prim_length,     // length field of the primitive
	input  wire logic        i_prim_to_mem,     // data moves from coprocessor to memory
	input  wire logic [1:0]  i_prim_ea_class,   // valid-address category of the primitive
	input  wire logic        i_ctrl_sel_known,  // control register select code recognised
	input  wire logic        i_status_transfer_flag, // status flag of the status primitive
	input  wire logic        i_scan_odd,        // scan program counter value is odd
	input  wire logic [7:0]  i_prim_vector,     // vector carried by a take primitive
	input  wire logic        i_supervisor,      // supervisor state bit
	input  wire logic        i_trace_cof_mode,  // trace on change of flow selected
	input  wire logic        i_trace_taken,     // pulse: pending trace was serviced
	input  wire logic        i_ctrl_write_done, // pulse: abort mask write completed
	input  wire logic        i_return_unchanged,// pulse: return from exception, frame intact
	output logic             o_busy,            // checker is classifying a word or sequencing an exception
	output logic             o_cp_start_ok,     // pulse: word may start coprocessor traffic
	output logic             o_ctrl_abort_req,  // level: write abort mask to control register
	output logic             o_exc_valid,       // pulse: begin exception processing
	output logic [7:0]       o_exc_vector,      // vector of that exception
	output logic [1:0]       o_exc_frame,       // stack frame of that exception
	output logic [2:0]       o_exc_kind,        // class of that exception
	output logic             o_addr_error,      // pulse: odd scan program counter
	output logic             o_trace_pending,   // level: trace made pending
	output logic             o_reread_response  // pulse: read the response register again
);
	// sequencer states
	typedef enum logic [2:0] {
		ST_IDLE  = 3'h1,
		ST_ABORT = 3'h2,
		ST_RAISE = 3'h4
	} cpx_state_t;

	cpx_op_if op (); // link to the operation word decoder

	cpx_state_t  state, next_state;           // sequencer state
	logic [15:0] cur_op, next_cur_op;         // operation word in progress
	logic        cur_known, next_cur_known;   // its recognition flag
	logic [7:0]  pend_vec, next_pend_vec;     // exception being raised
	logic [1:0]  pend_frame, next_pend_frame; // frame for it
	logic [2:0]  pend_kind, next_pend_kind;   // class for it
	logic        last_pv, next_last_pv;       // last exception was a protocol violation
	logic        trace_pend, next_trace_pend; // pending trace flag
	logic        start_ok, next_start_ok;     // registered start permission
	logic        addr_err, next_addr_err;     // registered address error pulse
	logic        reread, next_reread;         // registered re-read pulse
	logic        exc_fire, next_exc_fire;     // registered exception pulse

	// primitive evaluation results
	logic        pv;      // protocol violation
	logic        fl;      // line-F from the primitive, aborts coprocessor
	logic        priv;    // privilege violation
	logic        take;    // take-exception primitive
	logic [1:0]  take_fr; // frame named by the take primitive
	logic [2:0]  mode;    // address mode of the current word

	cpx_op_decoder u_dec (
		.op (op.dec)
	);

	// feed the decoder from the latched word
	always_comb begin
		op.op_word    = cur_op;
		op.recognised = cur_known;
		mode          = op.ea[5:3];
	end

	// classify the primitive just read
	always_comb begin
		pv      = 1'b0;
		fl      = 1'b0;
		priv    = 1'b0;
		take    = 1'b0;
		take_fr = FRAME_PRE4;
		// marked primitives need come-again inside conditionals
		if (op.conditional && prim_marked(i_prim_type) && !i_come_again_bit) begin
			pv = 1'b1;
		end
		case (i_prim_type)
			PRIM_BUSY, PRIM_NULL, PRIM_XFER_OPWORD, PRIM_TAKE_ADDR, PRIM_XFER_MREG,
			PRIM_XFER_MMULTI: begin
				// no primitive-specific checks
			end
			PRIM_SUPER_CHECK: begin
				if (!i_supervisor) priv = 1'b1;
			end
			PRIM_XFER_ISTRM: begin
				if (i_prim_length[0]) pv = 1'b1;
			end
			PRIM_EVAL_EA: begin
				if (op.conditional) pv = 1'b1;
				else if (!ea_ctrl_alt(op.ea)) fl = 1'b1;
			end
			PRIM_EVAL_DATA: begin
				if (op.conditional) pv = 1'b1;
				// register direct takes only byte, word or long
				else if ((mode == EAM_DREG || mode == EAM_AREG) && i_prim_length != LEN_BYTE &&
					i_prim_length != LEN_WORD && i_prim_length != LEN_LONG) pv = 1'b1;
				// immediate takes one byte or even lengths
				else if (mode == EAM_EXT && op.ea[2:0] == EAR_IMM && i_prim_length[0] &&
					i_prim_length != LEN_BYTE) pv = 1'b1;
				else if ((i_prim_to_mem && !ea_alterable(op.ea)) ||
					!ea_in_class(op.ea, i_prim_ea_class)) fl = 1'b1;
			end
			PRIM_WRITE_PREV: begin
				if (op.conditional) pv = 1'b1;
			end
			PRIM_XFER_TOS: begin
				if (i_prim_length != LEN_BYTE && i_prim_length != LEN_WORD &&
					i_prim_length != LEN_LONG) pv = 1'b1;
			end
			PRIM_XFER_MCTRL: begin
				if (!i_ctrl_sel_known) pv = 1'b1;
			end
			PRIM_XFER_CMULTI: begin
				if (op.conditional || i_prim_length[0]) pv = 1'b1;
				// postincrement only for memory writes, predecrement only for reads
				else if (!ea_ctrl_alt(op.ea) &&
					!(i_prim_to_mem && mode == EAM_POSTINC) &&
					!(!i_prim_to_mem && mode == EAM_PREDEC)) fl = 1'b1;
			end
			PRIM_XFER_STATUS: begin
				if (op.conditional) pv = 1'b1;
			end
			PRIM_TAKE_PRE: begin
				take = 1'b1;
			end
			PRIM_TAKE_MID: begin
				take    = 1'b1;
				take_fr = FRAME_MID10;
			end
			PRIM_TAKE_POST: begin
				take    = 1'b1;
				take_fr = FRAME_POST6;
			end
			default: begin
				pv = 1'b1;
			end
		endcase
	end

	// sequencer next values
	always_comb begin
		next_state      = state;
		next_cur_op     = cur_op;
		next_cur_known  = cur_known;
		next_pend_vec   = pend_vec;
		next_pend_frame = pend_frame;
		next_pend_kind  = pend_kind;
		next_last_pv    = last_pv;
		next_start_ok   = 1'b0;
		next_addr_err   = 1'b0;
		next_reread     = 1'b0;
		next_exc_fire   = 1'b0;
		// trace flag: a new set wins over a service in the same cycle
		next_trace_pend = trace_pend && !i_trace_taken;
		case (state)
			ST_IDLE: begin
				if (i_op_check) begin
					// latch the word; decision follows next cycle
					next_cur_op    = i_op_word;
					next_cur_known = i_op_recognised;
					next_state     = ST_RAISE;
					next_pend_kind = KIND_NONE;
				end else if (i_start_done && i_start_bus_error) begin
					// coprocessor absent
					next_pend_vec   = VEC_FLINE;
					next_pend_frame = FRAME_PRE4;
					next_pend_kind  = KIND_FLINE;
					next_state      = ST_RAISE;
				end else if (i_prim_valid) begin
					if (pv) begin
						next_pend_vec   = VEC_PROTOCOL;
						next_pend_frame = FRAME_MID10;
						next_pend_kind  = KIND_PROTOCOL;
						next_state      = ST_RAISE;
					end else if (fl || priv) begin
						next_pend_vec   = fl ? VEC_FLINE : VEC_PRIV;
						next_pend_frame = FRAME_PRE4;
						next_pend_kind  = fl ? KIND_FLINE : KIND_PRIV;
						next_state      = ST_ABORT;
					end else if (take) begin
						next_pend_vec   = i_prim_vector;
						next_pend_frame = take_fr;
						next_pend_kind  = KIND_TAKEN;
						next_state      = ST_RAISE;
					end else if (i_prim_type == PRIM_XFER_STATUS) begin
						if (i_trace_cof_mode && i_status_transfer_flag) next_trace_pend = 1'b1;
						next_addr_err = i_scan_odd;
					end
				end else if (i_return_unchanged && last_pv) begin
					next_reread  = 1'b1;
					next_last_pv = 1'b0;
				end
			end
			ST_ABORT: begin
				// hold the abort mask request until the write completes
				if (i_ctrl_write_done) next_state = ST_RAISE;
			end
			ST_RAISE: begin
				next_state = ST_IDLE;
				if (pend_kind == KIND_NONE) begin
					// operation word verdict, never preceded by a control write
					if (op.invalid) begin
						next_pend_vec   = VEC_FLINE;
						next_pend_frame = FRAME_PRE4;
						next_pend_kind  = KIND_FLINE;
						next_exc_fire   = 1'b1;
						next_last_pv    = 1'b0;
					end else begin
						next_start_ok = 1'b1;
					end
				end else begin
					next_exc_fire = 1'b1;
					next_last_pv  = (pend_kind == KIND_PROTOCOL);
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	// sequencer registers
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state      <= ST_IDLE;
			cur_op     <= 16'h0000;
			cur_known  <= 1'b0;
			pend_vec   <= 8'h00;
			pend_frame <= FRAME_PRE4;
			pend_kind  <= KIND_NONE;
			last_pv    <= 1'b0;
			trace_pend <= 1'b0;
			start_ok   <= 1'b0;
			addr_err   <= 1'b0;
			reread     <= 1'b0;
			exc_fire   <= 1'b0;
		end else begin
			state      <= next_state;
			cur_op     <= next_cur_op;
			cur_known  <= next_cur_known;
			pend_vec   <= next_pend_vec;
			pend_frame <= next_pend_frame;
			pend_kind  <= next_pend_kind;
			last_pv    <= next_last_pv;
			trace_pend <= next_trace_pend;
			start_ok   <= next_start_ok;
			addr_err   <= next_addr_err;
			reread     <= next_reread;
			exc_fire   <= next_exc_fire;
		end
	end

	// outputs: handshakes from state, data from registers
	always_comb begin
		o_busy            = (state != ST_IDLE);
		o_ctrl_abort_req  = (state == ST_ABORT);
		o_cp_start_ok     = start_ok;
		o_exc_valid       = exc_fire;
		o_exc_vector      = pend_vec;
		o_exc_frame       = pend_frame;
		o_exc_kind        = pend_kind;
		o_addr_error      = addr_err;
		o_trace_pending   = trace_pend;
		o_reread_response = reread;
	end
endmodule
`default_nettype wire

// ### cpx_checker_properties.sv
// concurrent checks on the exception checker's ports
// assumes one clock domain and the asynchronous active-low reset
`default_nettype none
module cpx_checker_properties
	import cpx_pkg::*;
(
	input wire logic        i_sys_clk,
	input wire logic        i_reset_n,
	input wire logic        i_op_check,
	input wire logic [15:0] i_op_word,
	input wire logic        i_op_recognised,
	input wire logic        i_start_done,
	input wire logic        i_start_bus_error,
	input wire logic        i_prim_valid,
	input wire logic [4:0]  i_prim_type,
	input wire logic        i_ctrl_write_done,
	input wire logic        i_return_unchanged,
	input wire logic        o_busy,
	input wire logic        o_cp_start_ok,
	input wire logic        o_ctrl_abort_req,
	input wire logic        o_exc_valid,
	input wire logic [7:0]  o_exc_vector,
	input wire logic [1:0]  o_exc_frame,
	input wire logic [2:0]  o_exc_kind,
	input wire logic        o_reread_response
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_reset_n);
	logic op_go;   // operation word taken
	logic prim_go; // primitive taken
	assign op_go = i_op_check && !o_busy;
	assign prim_go = i_prim_valid && !o_busy && !i_op_check && !(i_start_done && i_start_bus_error);
	// line-F two cycles on, no start and no abort write meanwhile
	sequence s_fline2;
		(!o_cp_start_ok && !o_ctrl_abort_req) ##1 (o_exc_valid && o_exc_kind == KIND_FLINE && !o_ctrl_abort_req);
	endsequence
	a_reserved_type_fline: assert property (op_go && i_op_word[8:7] == 2'b11 |=> s_fline2)
		else $error("reserved operation type did not give a quiet line-F");
	a_unknown_word_fline: assert property (op_go && i_op_word[8:6] <= 3'h5 && !i_op_recognised |=> s_fline2)
		else $error("unrecognised operation word did not give a quiet line-F");
	a_start_error_fline: assert property (i_start_done && i_start_bus_error && !o_busy && !i_op_check
		|-> ##2 (o_exc_valid && o_exc_kind == KIND_FLINE))
		else $error("bus error on start access did not give line-F");
	a_fline_frame: assert property (o_exc_valid && o_exc_kind == KIND_FLINE
		|-> o_exc_vector == VEC_FLINE && o_exc_frame == FRAME_PRE4)
		else $error("line-F vector or frame wrong");
	a_proto_frame: assert property (o_exc_valid && o_exc_kind == KIND_PROTOCOL
		|-> o_exc_vector == VEC_PROTOCOL && o_exc_frame == FRAME_MID10)
		else $error("protocol violation vector or frame wrong");
	a_proto_no_abort: assert property (o_exc_valid && o_exc_kind == KIND_PROTOCOL |-> !$past(o_ctrl_abort_req))
		else $error("protocol violation was preceded by an abort write");
	a_bad_prim_proto: assert property (prim_go && i_prim_type > 5'h11
		|-> ##2 (o_exc_valid && o_exc_kind == KIND_PROTOCOL))
		else $error("undecodable primitive did not raise a protocol violation");
	a_abort_held: assert property (o_ctrl_abort_req && !i_ctrl_write_done |=> o_ctrl_abort_req)
		else $error("abort request dropped before the write completed");
	a_abort_then_exc: assert property ($fell(o_ctrl_abort_req)
		|=> o_exc_valid && o_exc_kind inside {KIND_FLINE, KIND_PRIV})
		else $error("abort write not followed by exception processing");
	a_reread_after_proto: assert property (i_return_unchanged && !o_busy && !i_op_check && !i_prim_valid
		&& !(i_start_done && i_start_bus_error) && o_exc_kind == KIND_PROTOCOL |=> o_reread_response)
		else $error("response register not read again after return");
	c_priv: cover property (o_exc_valid && o_exc_kind == KIND_PRIV);
	c_reread: cover property (o_reread_response);
	c_abort: cover property ($fell(o_ctrl_abort_req));
endmodule
bind cpx_checker cpx_checker_properties cpx_checker_properties_i (.*);
`default_nettype wire

// ### cpx_cp_model.sv
// coprocessor side: acknowledges the abort mask write to its control register
// assumes the abort request stays up until the cycle after the write completes
`default_nettype none
module cpx_cp_model (
	input  wire logic       i_sys_clk,
	input  wire logic       i_reset_n,
	input  wire logic       i_abort_req, // abort mask write under way
	input  wire logic [3:0] i_delay,     // wait states before acknowledge
	output var  logic       o_write_done // pulse: write acknowledged
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] wait_cnt; // wait states spent
	logic       fired;    // one acknowledge per request
	// every access is acknowledged, promptly or late, never refused
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			wait_cnt <= 4'h0;
			fired <= 1'b0;
			o_write_done <= 1'b0;
		end else if (!i_abort_req) begin
			wait_cnt <= 4'h0;
			fired <= 1'b0;
			o_write_done <= 1'b0;
		end else begin
			// acknowledge once the wait states are spent
			o_write_done <= !fired && wait_cnt >= i_delay;
			fired <= fired || wait_cnt >= i_delay;
			wait_cnt <= wait_cnt + 4'h1;
		end
	end
endmodule
`default_nettype wire

// ### testbench.sv
// self-checking bench for the coprocessor primitive exception checker
// assumes inputs change at the falling edge and outputs are read there too
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
	$display("ERROR %s expected %0h seen %0h", n, e, g); end end
module testbench
	import cpx_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic        i_sys_clk, i_reset_n, i_op_check, i_op_recognised, i_start_done, i_start_bus_error;
	logic [15:0] i_op_word;
	logic        i_prim_valid, i_come_again_bit, i_prim_to_mem, i_ctrl_sel_known, i_status_transfer_flag;
	logic [4:0]  i_prim_type;
	logic [7:0]  i_prim_length, i_prim_vector;
	logic [1:0]  i_prim_ea_class;
	logic        i_scan_odd, i_supervisor, i_trace_cof_mode, i_trace_taken, i_ctrl_write_done;
	logic        i_return_unchanged, o_busy, o_cp_start_ok, o_ctrl_abort_req, o_exc_valid;
	logic [7:0]  o_exc_vector;
	logic [1:0]  o_exc_frame;
	logic [2:0]  o_exc_kind;
	logic        o_addr_error, o_trace_pending, o_reread_response;
	logic [3:0]  ack_delay; // coprocessor wait states
	logic        aerr;      // address error seen one cycle after a primitive
	int          mismatches, num_checks;
	cpx_checker cpx_checker_i (.*);
	cpx_cp_model cpx_cp_model_i (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_abort_req(o_ctrl_abort_req),
		.i_delay(ack_delay), .o_write_done(i_ctrl_write_done));
	// print the counts and the verdict, then stop
	task report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// offer an operation word; expect line-F or a start two cycles on
	task op(input logic [15:0] w, input logic r, input logic fl);
		@(negedge i_sys_clk);
		i_op_word = w;
		i_op_recognised = r;
		i_op_check = 1'b1;
		@(negedge i_sys_clk);
		`CHK("busy", 1'b1, o_busy)
		i_op_check = 1'b0;
		@(negedge i_sys_clk);
		`CHK("start_ok", ~fl, o_cp_start_ok)
		`CHK("exc_valid", fl, o_exc_valid)
		if (fl) `CHK("frame", FRAME_PRE4, o_exc_frame)
	endtask
	// offer a primitive; wait a bounded time for the expected exception
	task automatic prim(input logic [4:0] t, input logic [7:0] len, input logic [2:0] k, input logic [7:0] v,
		input logic [1:0] f);
		int n;
		int lim;
		lim = (k == KIND_NONE) ? 6 : 40;
		@(negedge i_sys_clk);
		i_prim_type = t;
		i_prim_length = len;
		i_prim_valid = 1'b1;
		@(negedge i_sys_clk);
		i_prim_valid = 1'b0;
		aerr = o_addr_error;
		for (n = 0; n < lim; n++) begin
			if (o_exc_valid === 1'b1) break;
			@(negedge i_sys_clk);
		end
		`CHK("exc_kind", k, (n < lim) ? o_exc_kind : KIND_NONE)
		if (k != KIND_NONE) begin
			`CHK("vector", v, o_exc_vector)
			`CHK("frame", f, o_exc_frame)
			if (n == lim) report_and_stop();
		end
	endtask
	// free-running clock, 50 ns period
	initial begin
		i_sys_clk = 1'b0;
		forever #25 i_sys_clk = ~i_sys_clk;
	end
	// cut a hang short
	initial begin
		repeat (20000) @(posedge i_sys_clk);
		mismatches++;
		report_and_stop();
	end
	// main sequence
	initial begin
		cpx_prim_t cond_list[5];
		cond_list = '{PRIM_EVAL_EA, PRIM_EVAL_DATA, PRIM_WRITE_PREV, PRIM_XFER_STATUS, PRIM_XFER_CMULTI};
		{i_reset_n, i_op_check, i_op_recognised, i_start_done, i_start_bus_error, i_prim_valid} = 6'h00;
		{i_prim_to_mem, i_status_transfer_flag, i_scan_odd, i_trace_cof_mode, i_trace_taken} = 5'h00;
		{i_come_again_bit, i_ctrl_sel_known, i_supervisor, i_return_unchanged} = 4'h e;
		{i_op_word, i_prim_type, i_prim_length, i_prim_vector, i_prim_ea_class} = {16'hf010, 5'h00, 8'h00, 8'h30, 2'h3};
		ack_delay = 4'h1;
		aerr = 1'b0;
		repeat (8) @(negedge i_sys_clk);
		i_reset_n = 1'b1;
		for (int t = 0; t < 8; t++) op({7'h78, t[2:0], 6'h10}, t > 5, 1'b1);
		op(16'hf010, 1'b1, 1'b0);
		@(negedge i_sys_clk);
		{i_start_done, i_start_bus_error} = 2'h3;
		@(negedge i_sys_clk);
		{i_start_done, i_start_bus_error} = 2'h0;
		@(negedge i_sys_clk);
		`CHK("exc_kind", KIND_FLINE, o_exc_kind)
		$display("test opword done");
		prim(5'h1f, 8'h02, KIND_PROTOCOL, VEC_PROTOCOL, FRAME_MID10);
		@(negedge i_sys_clk);
		i_return_unchanged = 1'b1;
		@(negedge i_sys_clk);
		i_return_unchanged = 1'b0;
		`CHK("reread", 1'b1, o_reread_response)
		prim(PRIM_XFER_ISTRM, 8'h03, KIND_PROTOCOL, VEC_PROTOCOL, FRAME_MID10);
		prim(PRIM_XFER_ISTRM, 8'h00, KIND_NONE, 8'h00, 2'h0);
		prim(PRIM_XFER_TOS, 8'h03, KIND_PROTOCOL, VEC_PROTOCOL, FRAME_MID10);
		prim(PRIM_XFER_TOS, 8'h02, KIND_NONE, 8'h00, 2'h0);
		i_ctrl_sel_known = 1'b0;
		prim(PRIM_XFER_MCTRL, 8'h04, KIND_PROTOCOL, VEC_PROTOCOL, FRAME_MID10);
		i_ctrl_sel_known = 1'b1;
		$display("test protocol done");
		op(16'hf050, 1'b1, 1'b0);
		foreach (cond_list[i]) prim(cond_list[i], 8'h02, KIND_PROTOCOL, VEC_PROTOCOL, FRAME_MID10);
		i_come_again_bit = 1'b0;
		prim(PRIM_XFER_TOS, 8'h02, KIND_PROTOCOL, VEC_PROTOCOL, FRAME_MID10);
		i_come_again_bit = 1'b1;
		$display("test conditional done");
		ack_delay = 4'h5;
		op(16'hf000, 1'b1, 1'b0);
		prim(PRIM_EVAL_EA, 8'h04, KIND_FLINE, VEC_FLINE, FRAME_PRE4);
		prim(PRIM_EVAL_DATA, 8'h03, KIND_PROTOCOL, VEC_PROTOCOL, FRAME_MID10);
		prim(PRIM_EVAL_DATA, 8'h04, KIND_NONE, 8'h00, 2'h0);
		i_prim_ea_class = EAC_MEMORY;
		prim(PRIM_EVAL_DATA, 8'h02, KIND_FLINE, VEC_FLINE, FRAME_PRE4);
		i_prim_ea_class = EAC_ANY;
		op(16'hf03c, 1'b1, 1'b0);
		prim(PRIM_EVAL_DATA, 8'h03, KIND_PROTOCOL, VEC_PROTOCOL, FRAME_MID10);
		prim(PRIM_EVAL_DATA, 8'h01, KIND_NONE, 8'h00, 2'h0);
		i_prim_to_mem = 1'b1;
		prim(PRIM_EVAL_DATA, 8'h02, KIND_FLINE, VEC_FLINE, FRAME_PRE4);
		op(16'hf018, 1'b1, 1'b0);
		prim(PRIM_XFER_CMULTI, 8'h04, KIND_NONE, 8'h00, 2'h0);
		prim(PRIM_XFER_CMULTI, 8'h03, KIND_PROTOCOL, VEC_PROTOCOL, FRAME_MID10);
		i_prim_to_mem = 1'b0;
		prim(PRIM_XFER_CMULTI, 8'h04, KIND_FLINE, VEC_FLINE, FRAME_PRE4);
		$display("test address done");
		ack_delay = 4'h0;
		i_supervisor = 1'b0;
		prim(PRIM_SUPER_CHECK, 8'h00, KIND_PRIV, VEC_PRIV, FRAME_PRE4);
		i_supervisor = 1'b1;
		{i_trace_cof_mode, i_status_transfer_flag, i_scan_odd} = 3'h7;
		prim(PRIM_XFER_STATUS, 8'h00, KIND_NONE, 8'h00, 2'h0);
		`CHK("addr_error", 1'b1, aerr)
		`CHK("trace", 1'b1, o_trace_pending)
		i_trace_taken = 1'b1;
		@(negedge i_sys_clk);
		i_trace_taken = 1'b0;
		`CHK("trace", 1'b0, o_trace_pending)
		prim(PRIM_TAKE_PRE, 8'h00, KIND_TAKEN, 8'h30, FRAME_PRE4);
		prim(PRIM_TAKE_MID, 8'h00, KIND_TAKEN, 8'h30, FRAME_MID10);
		prim(PRIM_TAKE_POST, 8'h00, KIND_TAKEN, 8'h30, FRAME_POST6);
		$display("test status done");
		report_and_stop();
	end
endmodule
`default_nettype wire
